/* inc/icc_regs_pkg.sv */
// Package for the physical interrupt CPU interface register set.
// Assumes a system-register access port with op0/op1/crn/crm/op2 encodings.
package icc_regs_pkg;

   // Encoding fields
   localparam logic [1:0] OP0_SYS     = 2'h3;
   localparam logic [3:0] CRN_IRQ     = 4'hc;
   localparam logic [2:0] OP1_EL1     = 3'h0;
   localparam logic [2:0] OP1_EL2     = 3'h4;
   localparam logic [2:0] OP1_EL3     = 3'h6;
   localparam logic [3:0] CRM_GRP0    = 4'h8;
   localparam logic [3:0] CRM_GRP1    = 4'h9;
   localparam logic [3:0] CRM_CTRL    = 4'hc;
   localparam logic [2:0] OP2_AP0     = 3'h4;
   localparam logic [2:0] OP2_AP1     = 3'h0;
   localparam logic [2:0] OP2_BPR     = 3'h3;
   localparam logic [2:0] OP2_CTLR    = 3'h4;
   localparam logic [2:0] OP2_SRE     = 3'h5;

   // Register indexes inside the small storage
   localparam logic [1:0] IDX_AP0     = 2'h0;
   localparam logic [1:0] IDX_AP1     = 2'h1;

   // Control register fields
   localparam int CTL_COMMON_SPLIT_POINT_SELECT_BIT        = 0;
   localparam int CTL_END_OF_INTERRUPT_MODE_BIT     = 1;
   localparam int CTL_PRIORITY_MASK_HINT_ENABLE_BIT        = 6;
   localparam int CTL_PRI_LSB         = 8;
   localparam int CTL_ID_LSB          = 11;
   localparam int CTL_SYSTEM_ERROR_IRQ_SUPPORT_BIT        = 14;
   localparam int CTL_A3V_BIT         = 15;
   localparam logic [2:0] PRI_BITS_VAL = 3'h4;
   localparam logic [2:0] ID_BITS_VAL  = 3'h0;
   localparam logic A3V_VAL           = 1'b1;
   localparam logic SYSTEM_ERROR_IRQ_SUPPORT_VAL          = 1'b0;

   // Split-point limits and reset values
   localparam logic [2:0] BPR0_MIN    = 3'h2;
   localparam logic [2:0] BPR1_MIN_S  = 3'h2;
   localparam logic [2:0] BPR1_MIN_NS = 3'h3;
   localparam logic [31:0] AP_RESET   = 32'h0000_0000;
   localparam logic [31:0] SRE_ENABLE = 32'h0000_0001;
   localparam int PRIO_STEP_LOG2      = 3;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_AP0  = 3'b001,
      SEL_AP1  = 3'b010,
      SEL_BPR0 = 3'b011,
      SEL_BPR1 = 3'b100,
      SEL_CTLR = 3'b101,
      SEL_SRE  = 3'b110
   } reg_sel_e;

   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } sysreg_enc_s;

endpackage : icc_regs_pkg

/* hdl/icc_ap_store.sv */
// Two-word active-priority store with registered read data.
// Assumes one write or read per cycle on the core clock.
`timescale 1ns/10ps
module icc_ap_store #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rstn_i,
   // Access
   input  wire logic                      wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0]  addr_i,
   input  wire logic [WIDTH-1:0]          wdata_i,
   output logic      [WIDTH-1:0]          rdata_o
);
   import icc_regs_pkg::*;

   logic [WIDTH-1:0] mem [DEPTH];

   // Both bitmaps start empty
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               mem[g] <= AP_RESET[WIDTH-1:0];
            end else if (wr_en_i && addr_i == g) begin
               mem[g] <= wdata_i;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule : icc_ap_store

/* hdl/icc_cpu_if_regs.sv */
// Physical interrupt CPU interface register set, system-register access.
// Assumes the core presents one access per cycle with its encoding and security state.
//
// Function
// - Group 0 active bitmap, one bit per level.
// - Separate group 1 active bitmap, same mapping.
// - Both bitmaps reset to zero.
// - Priority bits field reads 0x4.
// - Split-point field divides priority for preemption.
// - Group 0 split point never below 0x2.
// - Group 1 minimum 0x2 secure, 0x3 nonsecure.
// - Control bit 15 reads one.
// - Control bit 14 reads zero.
// - Identifier field mirrors EL3, 16-bit identifiers.
// - Bit 6 read-only mirror of EL3 hint.
// - Mode 0: end-of-interrupt drops and deactivates.
// - Mode 1: deactivate only via deactivate register.
// - Common bit selects group 0 split for both.
// - Decode op0 3, CRn 12, op1 0/4/6.
// - Enable registers' enable bit reads one.
`timescale 1ns/10ps
module icc_cpu_if_regs #(
   parameter int AP_WIDTH = 32
) (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rstn_i,
   // System register access
   input  wire logic                      sr_valid_i,
   input  wire logic                      sr_write_i,
   input  wire icc_regs_pkg::sysreg_enc_s sr_enc_i,
   input  wire logic                      sr_secure_i,
   input  wire logic [31:0]               sr_wdata_i,
   output logic      [31:0]               sr_rdata_o,
   output logic                           sr_rvalid_o,
   output logic                           sr_undef_o,
   // EL3 mirrors
   input  wire logic                      el3_priority_mask_hint_enable_i,
   input  wire logic [2:0]                el3_id_bits_i,
   // End-of-interrupt events
   input  wire logic                      eoi_write_i,
   input  wire logic                      dir_write_i,
   output logic                           prio_drop_o,
   output logic                           deactivate_o,
   output logic                           dir_unpredictable_o,
   // Preemption split in use and registered EL3 hint mirror
   output logic      [2:0]                grp0_split_o,
   output logic      [2:0]                grp1_split_o,
   output logic                           priority_mask_hint_enable_o
);
   import icc_regs_pkg::*;

   reg_sel_e   sel;
   logic [2:0] bpr0;
   logic [2:0] bpr1_s;
   logic [2:0] bpr1_ns;
   logic       eoi_mode;
   logic       common_split_point_select;
   logic [AP_WIDTH-1:0] ap_rdata;
   logic       ap_wr;
   logic [0:0] ap_addr;
   reg_sel_e   sel_q;
   logic [2:0] bpr1_min;
   logic [2:0] wsplit;
   logic [31:0] ctlr_val;

   // Encoding decode
   always_comb begin
      sel = SEL_NONE;
      if (sr_enc_i.op0 != OP0_SYS || sr_enc_i.crn != CRN_IRQ) begin
         sel = SEL_NONE;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_GRP0
                   && sr_enc_i.op2 == OP2_AP0) begin
         sel = SEL_AP0;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_GRP1
                   && sr_enc_i.op2 == OP2_AP1) begin
         sel = SEL_AP1;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_GRP0
                   && sr_enc_i.op2 == OP2_BPR) begin
         sel = SEL_BPR0;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_CTRL
                   && sr_enc_i.op2 == OP2_BPR) begin
         sel = SEL_BPR1;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_CTRL
                   && sr_enc_i.op2 == OP2_CTLR) begin
         sel = SEL_CTLR;
      end else if (sr_enc_i.op1 == OP1_EL1 && sr_enc_i.crm == CRM_CTRL
                   && sr_enc_i.op2 == OP2_SRE) begin
         sel = SEL_SRE;
      end else if (sr_enc_i.op1 == OP1_EL2 && sr_enc_i.crm == CRM_GRP1
                   && sr_enc_i.op2 == OP2_SRE) begin
         sel = SEL_SRE;
      end else if (sr_enc_i.op1 == OP1_EL3 && sr_enc_i.crm == CRM_CTRL
                   && sr_enc_i.op2 == OP2_SRE) begin
         sel = SEL_SRE;
      end
   end

   // Active-priority bitmaps
   assign ap_wr   = sr_valid_i && sr_write_i && (sel == SEL_AP0 || sel == SEL_AP1);
   assign ap_addr = (sel == SEL_AP1) ? IDX_AP1[0] : IDX_AP0[0];

   icc_ap_store #(
      .WIDTH (AP_WIDTH),
      .DEPTH (2)
   ) u_ap_store (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .wr_en_i    (ap_wr),
      .addr_i     (ap_addr),
      .wdata_i    (sr_wdata_i[AP_WIDTH-1:0]),
      .rdata_o    (ap_rdata)
   );

   // Split-point writes clamp to the minimum
   assign bpr1_min = sr_secure_i ? BPR1_MIN_S : BPR1_MIN_NS;
   assign wsplit   = sr_wdata_i[2:0];

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bpr0 <= BPR0_MIN;
      end else if (sr_valid_i && sr_write_i && sel == SEL_BPR0) begin
         bpr0 <= (wsplit < BPR0_MIN) ? BPR0_MIN : wsplit;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bpr1_s  <= BPR1_MIN_S;
         bpr1_ns <= BPR1_MIN_NS;
      end else if (sr_valid_i && sr_write_i && sel == SEL_BPR1) begin
         if (sr_secure_i) begin
            bpr1_s <= (wsplit < bpr1_min) ? bpr1_min : wsplit;
         end else begin
            bpr1_ns <= (wsplit < bpr1_min) ? bpr1_min : wsplit;
         end
      end
   end

   // Control register writable bits
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         eoi_mode <= 1'b0;
         common_split_point_select     <= 1'b0;
      end else if (sr_valid_i && sr_write_i && sel == SEL_CTLR) begin
         eoi_mode <= sr_wdata_i[CTL_END_OF_INTERRUPT_MODE_BIT];
         common_split_point_select     <= sr_wdata_i[CTL_COMMON_SPLIT_POINT_SELECT_BIT];
      end
   end

   always_comb begin
      ctlr_val = '0;
      ctlr_val[CTL_A3V_BIT]  = A3V_VAL;
      ctlr_val[CTL_SYSTEM_ERROR_IRQ_SUPPORT_BIT] = SYSTEM_ERROR_IRQ_SUPPORT_VAL;
      ctlr_val[CTL_ID_LSB +: 3]  = el3_id_bits_i;
      ctlr_val[CTL_PRI_LSB +: 3] = PRI_BITS_VAL;
      ctlr_val[CTL_PRIORITY_MASK_HINT_ENABLE_BIT]     = el3_priority_mask_hint_enable_i;
      ctlr_val[CTL_END_OF_INTERRUPT_MODE_BIT]  = eoi_mode;
      ctlr_val[CTL_COMMON_SPLIT_POINT_SELECT_BIT]     = common_split_point_select;
   end

   // Read path, answered one cycle after the access
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_q       <= SEL_NONE;
         sr_rvalid_o <= 1'b0;
         sr_undef_o  <= 1'b0;
      end else begin
         sel_q       <= sel;
         sr_rvalid_o <= sr_valid_i && !sr_write_i && sel != SEL_NONE;
         sr_undef_o  <= sr_valid_i && sel == SEL_NONE;
      end
   end

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      case (sel)
         SEL_BPR0: next_rdata = {29'h0, bpr0};
         SEL_BPR1: next_rdata = {29'h0, sr_secure_i ? bpr1_s : bpr1_ns};
         SEL_CTLR: next_rdata = ctlr_val;
         SEL_SRE:  next_rdata = SRE_ENABLE;
         default:  next_rdata = '0;
      endcase
   end

   logic [31:0] rdata_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= next_rdata;
      end
   end

   assign sr_rdata_o = (sel_q == SEL_AP0 || sel_q == SEL_AP1) ?
                       32'(ap_rdata) : rdata_q;

   // End-of-interrupt behaviour
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prio_drop_o         <= 1'b0;
         deactivate_o        <= 1'b0;
         dir_unpredictable_o <= 1'b0;
      end else begin
         prio_drop_o         <= eoi_write_i;
         deactivate_o        <= eoi_mode ? dir_write_i : eoi_write_i;
         dir_unpredictable_o <= !eoi_mode && dir_write_i;
      end
   end

   // Preemption split selection
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         grp0_split_o <= BPR0_MIN;
         grp1_split_o <= BPR1_MIN_NS;
         priority_mask_hint_enable_o       <= 1'b0;
      end else begin
         grp0_split_o <= bpr0;
         grp1_split_o <= common_split_point_select ? bpr0 : (sr_secure_i ? bpr1_s : bpr1_ns);
         priority_mask_hint_enable_o       <= el3_priority_mask_hint_enable_i;
      end
   end

endmodule : icc_cpu_if_regs

/* dv/irq_dist_model.sv */
// Distributor-side model: issues end-of-interrupt and deactivate pulses.
// Assumes the core clock of the register set.
`timescale 1ns/10ps
module irq_dist_model (
   input  wire logic core_clk_i,
   output logic      eoi_o,
   output logic      dir_o
);
   initial begin
      eoi_o = 1'b0;
      dir_o = 1'b0;
   end
   // One-cycle pulse after g idle cycles, so both prompt and slow senders occur
   task automatic pulse(input logic e, input logic d, input int g);
      repeat (g) @(posedge core_clk_i);
      @(posedge core_clk_i) #1;
      eoi_o = e;
      dir_o = d;
      @(posedge core_clk_i) #1;
      eoi_o = 1'b0;
      dir_o = 1'b0;
   endtask : pulse
endmodule : irq_dist_model

/* dv/icc_cpu_if_regs_asserts.sv */
// Checker on the register-set ports.
// Assumes one core clock and an active-low reset.
`timescale 1ns/10ps
module icc_regs_chk
   import icc_regs_pkg::*;
(
   input wire logic                      core_clk_i, rstn_i, sr_valid_i, sr_write_i,
   input wire icc_regs_pkg::sysreg_enc_s sr_enc_i,
   input wire logic [2:0]                el3_id_bits_i, grp0_split_o, grp1_split_o,
   input wire logic [31:0]               sr_rdata_o,
   input wire logic                      el3_priority_mask_hint_enable_i, eoi_write_i, dir_write_i,
   input wire logic                      sr_rvalid_o, sr_undef_o, prio_drop_o,
   input wire logic                      deactivate_o, dir_unpredictable_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   wire rd_ctl = sr_valid_i && !sr_write_i &&
      sr_enc_i == {OP0_SYS, OP1_EL1, CRN_IRQ, CRM_CTRL, OP2_CTLR};
   AST_CTL_FIXED: assert property (
      rd_ctl |=> sr_rvalid_o && sr_rdata_o[15:14] == 2'h2 && sr_rdata_o[10:8] == 3'h4)
      else $error("control feature fields wrong");
   AST_CTL_MIRROR: assert property (
      rd_ctl |=> sr_rdata_o[13:11] == $past(el3_id_bits_i) && sr_rdata_o[6] == $past(el3_priority_mask_hint_enable_i))
      else $error("control mirror fields wrong");
   AST_CTL_RES0: assert property (
      rd_ctl |=> {sr_rdata_o[31:16], sr_rdata_o[7], sr_rdata_o[5:2]} == 21'h0)
      else $error("control reserved bits set");
   AST_SPLIT_MIN: assert property (
      grp0_split_o >= 3'h2 && grp1_split_o >= 3'h2)
      else $error("split point below minimum");
   AST_EOI_DROP: assert property (
      eoi_write_i |=> prio_drop_o)
      else $error("no priority drop after end of interrupt");
   AST_DEACT_CAUSE: assert property (
      deactivate_o |-> $past(eoi_write_i) || $past(dir_write_i))
      else $error("deactivate without cause");
   AST_DIR_ONE: assert property (
      dir_write_i && !eoi_write_i |=> deactivate_o != dir_unpredictable_o)
      else $error("deactivate write outcome wrong");
   AST_EL3_UNDEF: assert property (
      sr_valid_i && sr_enc_i.op1 == OP1_EL3 && sr_enc_i.op2 == OP2_CTLR
      |=> sr_undef_o && !sr_rvalid_o)
      else $error("unmapped access not refused");
endmodule : icc_regs_chk
bind icc_cpu_if_regs icc_regs_chk chk_u (.*);

/* dv/icc_cpu_if_regs_tb.sv */
// Bench for the interrupt CPU interface register set.
// Assumes the distributor model and the bound checker.
`timescale 1ns/10ps
module icc_cpu_if_regs_tb;
   import icc_regs_pkg::*;
   logic        core_clk_i, rstn_i, sr_valid_i, sr_write_i, sr_secure_i, el3_priority_mask_hint_enable_i;
   logic        eoi_write_i, dir_write_i, sr_rvalid_o, sr_undef_o, prio_drop_o;
   logic        deactivate_o, dir_unpredictable_o, priority_mask_hint_enable_o;
   logic [2:0]  el3_id_bits_i, grp0_split_o, grp1_split_o;
   logic [31:0] sr_wdata_i, sr_rdata_o;
   sysreg_enc_s sr_enc_i;
   int          err_count, check_count;
   wire  [2:0]  ev = {prio_drop_o, deactivate_o, dir_unpredictable_o};
   icc_cpu_if_regs dut_u (.*);
   irq_dist_model dist_u (.core_clk_i, .eoi_o(eoi_write_i), .dir_o(dir_write_i));
   function automatic sysreg_enc_s mk(logic [2:0] a, logic [3:0] m, logic [2:0] b);
      return {OP0_SYS, a, CRN_IRQ, m, b};
   endfunction : mk
   localparam sysreg_enc_s EAP0 = mk(OP1_EL1, CRM_GRP0, OP2_AP0),
      EAP1 = mk(OP1_EL1, CRM_GRP1, OP2_AP1), EBP0 = mk(OP1_EL1, CRM_GRP0, OP2_BPR),
      EBP1 = mk(OP1_EL1, CRM_CTRL, OP2_BPR), ECTL = mk(OP1_EL1, CRM_CTRL, OP2_CTLR),
      ESR1 = mk(OP1_EL1, CRM_CTRL, OP2_SRE), ESR2 = mk(OP1_EL2, CRM_GRP1, OP2_SRE),
      ESR3 = mk(OP1_EL3, CRM_CTRL, OP2_SRE), ECT3 = mk(OP1_EL3, CRM_CTRL, OP2_CTLR);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One access; u marks an unmapped encoding
   task automatic ac(input logic w, input sysreg_enc_s e, input logic [31:0] d,
                     input logic s, input logic u);
      @(posedge core_clk_i) #1;
      sr_valid_i = 1'b1;
      sr_write_i = w;
      sr_enc_i = e;
      sr_wdata_i = d;
      sr_secure_i = s;
      @(posedge core_clk_i) #1;
      sr_valid_i = 1'b0;
      chk(32'({sr_undef_o, sr_rvalid_o}), 32'({u, !w && !u}));
   endtask : ac
   task automatic wr(input sysreg_enc_s e, input logic [31:0] d, input logic s);
      ac(1'b1, e, d, s, 1'b0);
   endtask : wr
   task automatic rc(input sysreg_enc_s e, input logic s, input logic [31:0] x);
      ac(1'b0, e, 32'h0, s, 1'b0);
      chk(sr_rdata_o, x);
   endtask : rc
   task automatic t_reset;
      rc(EAP0, 1'b0, 32'h0);
      rc(EAP1, 1'b0, 32'h0);
      rc(EBP0, 1'b0, 32'h2);
      rc(EBP1, 1'b0, 32'h3);
      wr(ESR1, 32'h0, 1'b0);
      rc(ESR1, 1'b0, SRE_ENABLE);
      rc(ESR2, 1'b0, SRE_ENABLE);
      rc(ESR3, 1'b0, SRE_ENABLE);
   endtask : t_reset
   task automatic t_active;
      wr(EAP0, 32'h8000_0001, 1'b0);
      wr(EAP1, 32'h0000_0002, 1'b0);
      rc(EAP0, 1'b0, 32'h8000_0001);
      rc(EAP1, 1'b0, 32'h0000_0002);
   endtask : t_active
   task automatic t_ctrl;
      el3_priority_mask_hint_enable_i = 1'b1;
      wr(ECTL, 32'hffff_ffff, 1'b0);
      rc(ECTL, 1'b0, 32'h0000_8443);
      chk(32'(priority_mask_hint_enable_o), 32'h1);
      el3_priority_mask_hint_enable_i = 1'b0;
      wr(ECTL, 32'h0, 1'b0);
      rc(ECTL, 1'b0, 32'h0000_8400);
      chk(32'(priority_mask_hint_enable_o), 32'h0);
   endtask : t_ctrl
   task automatic t_split;
      wr(EBP0, 32'hffff_fff0, 1'b0);
      rc(EBP0, 1'b0, 32'h2);
      wr(EBP0, 32'h5, 1'b0);
      rc(EBP0, 1'b0, 32'h5);
      wr(EBP1, 32'h1, 1'b1);
      rc(EBP1, 1'b1, 32'h2);
      wr(EBP1, 32'h1, 1'b0);
      rc(EBP1, 1'b0, 32'h3);
      chk(32'(grp1_split_o), 32'h3);
      wr(ECTL, 32'h1, 1'b0);
      @(posedge core_clk_i) #1;
      chk(32'(grp0_split_o), 32'h5);
      chk(32'(grp1_split_o), 32'h5);
   endtask : t_split
   task automatic t_eoi;
      wr(ECTL, 32'h0, 1'b0);
      dist_u.pulse(1'b1, 1'b0, 0);
      chk(32'(ev), 32'h6);
      dist_u.pulse(1'b0, 1'b1, 3);
      chk(32'(ev), 32'h1);
      wr(ECTL, 32'h2, 1'b0);
      dist_u.pulse(1'b1, 1'b0, 0);
      chk(32'(ev), 32'h4);
      dist_u.pulse(1'b0, 1'b1, 2);
      chk(32'(ev), 32'h2);
   endtask : t_eoi
   task automatic t_undef;
      ac(1'b1, ECT3, 32'hffff_ffff, 1'b0, 1'b1);
      ac(1'b0, {2'h2, OP1_EL1, CRN_IRQ, CRM_CTRL, OP2_CTLR}, 32'h0, 1'b0, 1'b1);
      ac(1'b1, {OP0_SYS, OP1_EL1, 4'hb, CRM_CTRL, OP2_CTLR}, 32'h0, 1'b0, 1'b1);
      rc(ECTL, 1'b0, 32'h0000_8402);
   endtask : t_undef
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end
   initial begin
      {rstn_i, sr_valid_i, sr_write_i, sr_secure_i, el3_priority_mask_hint_enable_i} = 5'h0;
      {el3_id_bits_i, sr_wdata_i, sr_enc_i} = '0;
      err_count = 0;
      check_count = 0;
      repeat (12) @(posedge core_clk_i);
      #1 rstn_i = 1'b1;
      t_reset();
      t_active();
      t_ctrl();
      t_split();
      t_eoi();
      t_undef();
      end_of_test();
   end
endmodule : icc_cpu_if_regs_tb
